// ===== privileged_enclave_op_gate.sv
`timescale 1ns/1ps
`include "enclave_gate_defines.svh"
// Function
// RULE_01: Recognise opcode ending 01 CF, no prefix
// RULE_02: Leaf from accumulator, upper half ignored
// RULE_03: Three other registers are leaf-specific
// RULE_04: Active transaction diverts first to abort
// RULE_05: Invalid opcode if unprotected, v86 or SYSTEM_MANAGEMENT_MODE
// RULE_06: Invalid opcode unless privilege level 0
// RULE_07: Invalid opcode if capability bit clear
// RULE_08: Invalid opcode on lock/osize/rep/vex prefix
// RULE_09: Guest exit per leaf bitmap bit
// RULE_10: Protection fault if lock or enable clear
// RULE_11: Protection fault on unsupported leaf
// RULE_12: Protection fault if paging off, after leaf
// RULE_13: Protection fault on expand-down data segment
// RULE_14: 32 or 64-bit addressing by mode
// RULE_15: Segment, address-size, REX prefixes ignored
// RULE_16: Compatibility mode uses protected-mode faults
// RULE_17: Dispatch leaf only after all checks
// RULE_18: Restrictions apply on shared protected page
// RULE_19: Software serialises non-concurrent pairs
// RULE_20: Concurrent pairs may overlap freely
// RULE_21: Conditional pairs complete with error code
// RULE_22: User-error pairs complete unrestricted
// RULE_23: Page block leaf concurrent on control page
// RULE_24: Disallowed concurrency raises an exception
// RULE_25: Fixed check order, first match reported
module privileged_enclave_op_gate (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Dispatch to leaf flows
    output logic dispatch,
    output enclave_gate_pkg::result_type result
);

    // Software-written request state
    logic [31:0] opcode_reg;
    logic [31:0] mode_reg;
    logic [31:0] leaf_lo_reg;
    logic [31:0] leaf_hi_reg;
    logic [63:0] bmap_reg;
    logic [31:0] peer_reg;
    // Bus state
    logic ready_reg;
    logic [31:0] rdata_reg;
    logic err_reg;
    logic [31:0] rdata_next;
    logic hit_next;
    // Sequencing
    logic start_reg;
    logic dispatch_reg;
    logic done_reg;
    enclave_gate_pkg::result_type result_reg;
    enclave_gate_pkg::result_type result_next;
    // Decoded conditions
    logic [31:0] leaf;
    logic is64;
    logic ud_hit;
    logic exit_hit;
    logic leaf_ok;
    logic do_wr;
    // Packed operand roles {rbx, rcx, rdx} of the selected leaf
    logic [5:0] role_bits;

    // States of the evaluation sequencer
    typedef enum logic {
        st_idle,
        st_eval
    } state_type;
    state_type state_reg;

    // Operand roles per leaf
    function automatic logic [5:0] roles(input logic [7:0] lf);
        logic [5:0] r;
        r = {2'd1, 2'd1, 2'd0};
        unique case (lf)
            8'h02, 8'h07, 8'h08, 8'h0B: r = {2'd1, 2'd1, 2'd1};
            8'h03, 8'h09, 8'h0C: r = {2'd0, 2'd1, 2'd0};
            8'h04: r = {2'd2, 2'd1, 2'd0};
            default: r = {2'd1, 2'd1, 2'd0};
        endcase
        return r;
    endfunction

    // Class of this leaf against a leaf on another processor
    function automatic enclave_gate_pkg::conc_type classify(
        input logic [7:0] row,
        input logic [31:0] peer
    );
        logic [7:0] col;
        logic reload_r;
        logic reload_c;
        col = peer[`PR_LEAF];
        reload_r = (row == `LEAF_LDB) || (row == `LEAF_LDU);
        reload_c = (col == `LEAF_LDB) || (col == `LEAF_LDU);
        if (!peer[`PR_ACTIVE] || !peer[`PR_SAME])
            return enclave_gate_pkg::conc_y; // RULE_18 RULE_20
        if (peer[`PR_IMPL] && row == `LEAF_BLOCK)
            return enclave_gate_pkg::conc_y; // RULE_23
        if (row == `LEAF_TRACK && col == `LEAF_TRACK)
            return enclave_gate_pkg::conc_n; // RULE_19
        if (reload_r && reload_c)
            return enclave_gate_pkg::conc_c; // RULE_21
        return enclave_gate_pkg::conc_u; // RULE_22
    endfunction

    // Write qualifier: completes at the edge that sees pready
    assign do_wr = psel && penable && ready_reg && pwrite;

    // One wait state on every access keeps pready registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready_reg <= 1'b0;
            rdata_reg <= `RST_WORD;
            err_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= psel && penable && !ready_reg;
            rdata_reg <= rdata_next;
            err_reg <= psel && penable && !ready_reg && !hit_next;
        end
    end

    // Read mux and address decode
    always_comb
    begin
        hit_next = 1'b1;
        rdata_next = `RST_WORD;
        unique case (paddr)
            `OFS_OPCODE: rdata_next = opcode_reg;
            `OFS_MODE: rdata_next = mode_reg;
            `OFS_LEAF_LO: rdata_next = leaf_lo_reg;
            `OFS_LEAF_HI: rdata_next = leaf_hi_reg;
            `OFS_BMAP_LO: rdata_next = bmap_reg[31:0];
            `OFS_BMAP_HI: rdata_next = bmap_reg[63:32];
            `OFS_PEER: rdata_next = peer_reg;
            `OFS_CMD: rdata_next = {31'd0, state_reg == st_eval};
            // Done flag sits just above the 21-bit answer bundle
            `OFS_RESULT: rdata_next = {10'd0, done_reg, result_reg};
            default: hit_next = 1'b0;
        endcase
    end

    // Request registers; prefixes that are ignored are not stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opcode_reg <= `RST_WORD;
            mode_reg <= `RST_WORD;
            leaf_lo_reg <= `RST_WORD;
            leaf_hi_reg <= `RST_WORD;
            bmap_reg <= {`RST_WORD, `RST_WORD};
            peer_reg <= `RST_WORD;
        end
        else if (do_wr)
        begin
            unique case (paddr)
                `OFS_OPCODE: opcode_reg <= {4'd0, pwdata[27:0]}; // RULE_15
                `OFS_MODE: mode_reg <= {17'd0, pwdata[14:0]};
                `OFS_LEAF_LO: leaf_lo_reg <= pwdata;
                `OFS_LEAF_HI: leaf_hi_reg <= pwdata;
                `OFS_BMAP_LO: bmap_reg[31:0] <= pwdata;
                `OFS_BMAP_HI: bmap_reg[63:32] <= pwdata;
                `OFS_PEER: peer_reg <= {21'd0, pwdata[10:0]};
                default:
                begin
                end
            endcase
        end
    end

    // Start pulse from a command write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_reg <= 1'b0;
        else
            start_reg <= do_wr && paddr == `OFS_CMD && pwdata[`CMD_START];
    end

    // Sequencer: one evaluation cycle per start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= st_idle;
        else
            unique case (state_reg)
                st_idle: if (start_reg) state_reg <= st_eval;
                st_eval: state_reg <= st_idle;
            endcase
    end

    // Upper accumulator half never reaches the leaf choice
    assign leaf = leaf_lo_reg; // RULE_02
    // Long mode plus 64-bit code segment; code default size unused
    assign is64 = mode_reg[`MD_LMA] && mode_reg[`MD_CSL]; // RULE_14
    // Same checks serve protected and compatibility mode
    assign ud_hit = !mode_reg[`MD_PE] || mode_reg[`MD_VM] // RULE_05 RULE_16
        || mode_reg[`MD_SMM] // RULE_05
        || mode_reg[`MD_CPL] != 2'd0 // RULE_06
        || !mode_reg[`MD_CAP] // RULE_07
        || opcode_reg[`OPC_LOCK] || opcode_reg[`OPC_OSIZE] // RULE_08
        || opcode_reg[`OPC_REP] || opcode_reg[`OPC_VEX]; // RULE_08
    // Leaves above 62 share the last bitmap bit
    assign exit_hit = mode_reg[`MD_GUEST] && mode_reg[`MD_EXITCTL]
        && (leaf < `EXIT_SPLIT ? bmap_reg[leaf[5:0]] : bmap_reg[63]); // RULE_09
    assign leaf_ok = leaf <= `LEAF_MAX; // RULE_11
    // Roles are looked up once; each field is cast to its enum below
    assign role_bits = roles(leaf[7:0]); // RULE_03

    // Checks in fixed priority; the first match wins
    always_comb
    begin
        result_next.leaf = leaf[7:0];
        result_next.addr64 = is64; // RULE_14
        // Enum fields take no raw vector, hence the explicit casts
        result_next.rbx = enclave_gate_pkg::gpr_role_type'(role_bits[5:4]);
        result_next.rcx = enclave_gate_pkg::gpr_role_type'(role_bits[3:2]);
        result_next.rdx = enclave_gate_pkg::gpr_role_type'(role_bits[1:0]);
        result_next.conc = classify(leaf[7:0], peer_reg);
        if (opcode_reg[`OPC_BYTES] != `OPCODE_VAL)
            result_next.outcome = enclave_gate_pkg::out_not_ours; // RULE_01
        else if (mode_reg[`MD_TSX])
            result_next.outcome = enclave_gate_pkg::out_abort; // RULE_04 RULE_25
        else if (ud_hit)
            result_next.outcome = enclave_gate_pkg::out_ud; // RULE_25
        else if (exit_hit)
            result_next.outcome = enclave_gate_pkg::out_vmexit; // RULE_25
        else if (!mode_reg[`MD_LOCK] || !mode_reg[`MD_EN])
            result_next.outcome = enclave_gate_pkg::out_gp; // RULE_10
        else if (!leaf_ok)
            result_next.outcome = enclave_gate_pkg::out_gp; // RULE_11
        else if (!mode_reg[`MD_PG])
            result_next.outcome = enclave_gate_pkg::out_gp; // RULE_12
        else if (!is64 && mode_reg[`MD_DSEXP])
            result_next.outcome = enclave_gate_pkg::out_gp; // RULE_13
        else if (result_next.conc == enclave_gate_pkg::conc_n)
            result_next.outcome = enclave_gate_pkg::out_conc_fault; // RULE_24
        else if (result_next.conc == enclave_gate_pkg::conc_c)
            result_next.outcome = enclave_gate_pkg::out_dispatch_err; // RULE_21
        else
            result_next.outcome = enclave_gate_pkg::out_dispatch; // RULE_17
    end

    // Result capture and dispatch pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_reg <= '0;
            dispatch_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            dispatch_reg <= 1'b0;
            if (start_reg)
            begin
                result_reg <= result_next;
                done_reg <= 1'b1;
                // Leaf flow starts only once nothing faulted
                dispatch_reg <= result_next.outcome ==
                    enclave_gate_pkg::out_dispatch || result_next.outcome ==
                    enclave_gate_pkg::out_dispatch_err; // RULE_17
            end
        end
    end

    // Outputs straight from flip-flops
    assign pready = ready_reg;
    assign prdata = rdata_reg;
    assign pslverr = err_reg;
    assign dispatch = dispatch_reg;
    assign result = result_reg;

    // Checks beside the logic
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_abort_first: assert property ( // RULE_04
        start_reg && mode_reg[`MD_TSX] && opcode_reg[23:0] == `OPCODE_VAL
        |=> result_reg.outcome == enclave_gate_pkg::out_abort && !dispatch)
        else $error("transaction did not abort first");
    a_ud_priv: assert property ( // RULE_06
        start_reg && !mode_reg[`MD_TSX] && mode_reg[`MD_CPL] != 2'd0
        && opcode_reg[23:0] == `OPCODE_VAL
        |=> result_reg.outcome == enclave_gate_pkg::out_ud)
        else $error("privilege fault missing");
    a_ud_prefix: assert property ( // RULE_08
        start_reg && !mode_reg[`MD_TSX] && opcode_reg[`OPC_LOCK]
        && opcode_reg[23:0] == `OPCODE_VAL
        |=> result_reg.outcome == enclave_gate_pkg::out_ud)
        else $error("prefix fault missing");
    a_exit_bitmap: assert property ( // RULE_09
        start_reg && !mode_reg[`MD_TSX] && !ud_hit && exit_hit
        && opcode_reg[23:0] == `OPCODE_VAL
        |=> result_reg.outcome == enclave_gate_pkg::out_vmexit)
        else $error("hypervisor exit missing");
    a_gp_feature: assert property ( // RULE_10
        start_reg && !mode_reg[`MD_TSX] && !ud_hit && !exit_hit
        && !mode_reg[`MD_EN] && opcode_reg[23:0] == `OPCODE_VAL
        |=> result_reg.outcome == enclave_gate_pkg::out_gp)
        else $error("feature fault missing");
    a_gp_leaf: assert property ( // RULE_11
        start_reg && leaf > `LEAF_MAX |=> !dispatch)
        else $error("bad leaf dispatched");
    a_gp_paging: assert property ( // RULE_12
        start_reg && !mode_reg[`MD_PG] |=> !dispatch)
        else $error("dispatch with paging off");
    a_ds_expand: assert property ( // RULE_13
        start_reg && !is64 && mode_reg[`MD_DSEXP] |=> !dispatch)
        else $error("dispatch on expand-down segment");
    a_dispatch_ok: assert property ( // RULE_17
        dispatch |-> $past(start_reg) && (result.outcome ==
        enclave_gate_pkg::out_dispatch || result.outcome ==
        enclave_gate_pkg::out_dispatch_err))
        else $error("dispatch without clean checks");
    a_conc_fault: assert property ( // RULE_24
        dispatch |-> result.conc != enclave_gate_pkg::conc_n)
        else $error("serialised pair dispatched");
    a_ready_once: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("ready not one cycle");
    // Foreign opcodes never fault and never reach a leaf flow
    a_not_ours: assert property ( // RULE_01
        start_reg && opcode_reg[23:0] != `OPCODE_VAL
        |=> result_reg.outcome == enclave_gate_pkg::out_not_ours
        && !dispatch)
        else $error("foreign opcode was decoded");
    a_ud_mode: assert property ( // RULE_05
        start_reg && !mode_reg[`MD_TSX] && opcode_reg[23:0] == `OPCODE_VAL
        && (!mode_reg[`MD_PE] || mode_reg[`MD_VM] || mode_reg[`MD_SMM])
        |=> result_reg.outcome == enclave_gate_pkg::out_ud)
        else $error("mode fault missing");
    a_ud_capability: assert property ( // RULE_07
        start_reg && !mode_reg[`MD_TSX] && !mode_reg[`MD_CAP]
        && opcode_reg[23:0] == `OPCODE_VAL
        |=> result_reg.outcome == enclave_gate_pkg::out_ud)
        else $error("capability fault missing");
    // High leaves all share the last bitmap bit
    a_exit_high: assert property ( // RULE_09
        start_reg && !mode_reg[`MD_TSX] && !ud_hit
        && opcode_reg[23:0] == `OPCODE_VAL && mode_reg[`MD_GUEST]
        && mode_reg[`MD_EXITCTL] && leaf > 32'd62 && bmap_reg[63]
        |=> result_reg.outcome == enclave_gate_pkg::out_vmexit)
        else $error("high leaf exit missing");
    a_cond_error: assert property ( // RULE_21
        dispatch && result.conc == enclave_gate_pkg::conc_c
        |-> result.outcome == enclave_gate_pkg::out_dispatch_err)
        else $error("conditional pair without error");
    a_leaf_field: assert property ( // RULE_02
        start_reg |=> result_reg.leaf == $past(leaf_lo_reg[7:0]))
        else $error("leaf not taken from low word");
    // One pulse per evaluation, never a level
    a_dispatch_pulse: assert property ( // RULE_17
        dispatch |=> !dispatch)
        else $error("dispatch longer than one cycle");

    c_dispatch: cover property (dispatch);
    c_vmexit: cover property (
        result.outcome == enclave_gate_pkg::out_vmexit);
    c_conc_err: cover property (
        result.outcome == enclave_gate_pkg::out_dispatch_err);
    c_bad_addr: cover property (pslverr);
    c_abort: cover property (
        result.outcome == enclave_gate_pkg::out_abort);

endmodule

// ===== enclave_gate_defines.svh
`ifndef ENCLAVE_GATE_DEFINES_SVH
`define ENCLAVE_GATE_DEFINES_SVH

// Register byte offsets
`define OFS_OPCODE 12'h000
`define OFS_MODE 12'h004
`define OFS_LEAF_LO 12'h008
`define OFS_LEAF_HI 12'h00C
`define OFS_BMAP_LO 12'h010
`define OFS_BMAP_HI 12'h014
`define OFS_PEER 12'h018
`define OFS_CMD 12'h01C
`define OFS_RESULT 12'h020

// Opcode register fields
`define OPC_BYTES 23:0
`define OPC_LOCK 24
`define OPC_OSIZE 25
`define OPC_REP 26
`define OPC_VEX 27

// Mode register fields
`define MD_PE 0
`define MD_PG 1
`define MD_VM 2
`define MD_SMM 3
`define MD_CPL 5:4
`define MD_CAP 6
`define MD_LOCK 7
`define MD_EN 8
`define MD_LMA 9
`define MD_CSL 10
`define MD_DSEXP 11
`define MD_TSX 12
`define MD_GUEST 13
`define MD_EXITCTL 14

// Peer register fields
`define PR_LEAF 7:0
`define PR_ACTIVE 8
`define PR_SAME 9
`define PR_IMPL 10

// Command bit
`define CMD_START 0

// Constant values
`define OPCODE_VAL 24'h0F_01CF
`define LEAF_MAX 32'h0000_000F
`define LEAF_LDB 8'h07
`define LEAF_LDU 8'h08
`define LEAF_BLOCK 8'h09
`define LEAF_TRACK 8'h0C
`define EXIT_SPLIT 32'h0000_003F
`define RST_WORD 32'h0000_0000

`endif

// ===== enclave_gate_pkg.sv
package enclave_gate_pkg;

    // Outcome of one evaluation
    typedef enum logic [3:0] {
        out_none,
        out_abort,
        out_ud,
        out_vmexit,
        out_gp,
        out_conc_fault,
        out_dispatch,
        out_dispatch_err,
        out_not_ours
    } outcome_type;

    // Concurrency class of a leaf pair
    typedef enum logic [1:0] {
        conc_y,
        conc_n,
        conc_c,
        conc_u
    } conc_type;

    // Operand role of one general register
    typedef enum logic [1:0] {
        gpr_unused,
        gpr_in,
        gpr_out
    } gpr_role_type;

    // Registered answer bundle
    typedef struct packed {
        outcome_type outcome;
        logic [7:0] leaf;
        logic addr64;
        conc_type conc;
        gpr_role_type rbx;
        gpr_role_type rcx;
        gpr_role_type rdx;
    } result_type;

endpackage

// ===== test_privileged_enclave_op_gate.sv
`timescale 1ns/1ps
`include "enclave_gate_defines.svh"
module test_privileged_enclave_op_gate;
    // Clock, reset and APB master side
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Leaf dispatch side
    logic dispatch;
    enclave_gate_pkg::result_type result;
    // Bench bookkeeping
    int err_count = 0;
    int n_compared = 0;
    int disp_n = 0;
    int tno = 0;
    // Healthy ring-0 protected mode with paging, capability and enable set
    localparam logic [31:0] GOOD = 32'h0000_01C3;
    localparam logic [31:0] OPC = 32'h000F_01CF;

    privileged_enclave_op_gate DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dispatch(dispatch),
        .result(result)
    );

    // Free-running 100 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Count dispatch pulses so a missing or doubled pulse shows up
    always @(posedge pclk)
    begin
        if (dispatch === 1'b1)
            disp_n++;
    end

    // Hang guard, far above the expected run length
    initial
    begin
        #200000;
        err_count++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_compared++;
        if (got !== ex)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // One APB transfer; an idle edge follows so no signal is set twice
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer however long; only the watchdog ends a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Expected roles {rbx, rcx, rdx}: 0 unused, 1 input, 2 output
    function automatic logic [5:0] exp_roles(input logic [7:0] lf);
        if (lf == 8'h02 || lf == 8'h07 || lf == 8'h08 || lf == 8'h0B)
            return 6'h15;
        if (lf == 8'h03 || lf == 8'h09 || lf == 8'h0C)
            return 6'h04;
        if (lf == 8'h04)
            return 6'h24;
        return 6'h14;
    endfunction

    function automatic logic rl(input logic [7:0] l);
        return l == `LEAF_LDB || l == `LEAF_LDU;
    endfunction

    // Expected outcome, checks taken strictly in documented order
    function automatic enclave_gate_pkg::outcome_type exp_out(
        input logic [31:0] op, input logic [31:0] m, input logic [31:0] lf,
        input logic [63:0] bm, input logic [31:0] pr);
        logic col;
        col = pr[`PR_ACTIVE] & pr[`PR_SAME];
        if (op[`OPC_BYTES] != `OPCODE_VAL)
            return enclave_gate_pkg::out_not_ours;
        if (m[`MD_TSX])
            return enclave_gate_pkg::out_abort;
        if (!m[`MD_PE] || m[`MD_VM] || m[`MD_SMM] || !m[`MD_CAP] ||
            op[27:24] != 4'h0 || m[`MD_CPL] != 2'h0)
            return enclave_gate_pkg::out_ud;
        if (m[`MD_GUEST] && m[`MD_EXITCTL] &&
            ((lf < 63 && bm[lf[5:0]]) || (lf > 62 && bm[63])))
            return enclave_gate_pkg::out_vmexit;
        if (!m[`MD_LOCK] || !m[`MD_EN] || lf > `LEAF_MAX || !m[`MD_PG] ||
            (!(m[`MD_LMA] && m[`MD_CSL]) && m[`MD_DSEXP]))
            return enclave_gate_pkg::out_gp;
        if (col && !(lf[7:0] == `LEAF_BLOCK && pr[`PR_IMPL]))
        begin
            if (lf[7:0] == `LEAF_TRACK && pr[`PR_LEAF] == `LEAF_TRACK)
                return enclave_gate_pkg::out_conc_fault;
            if (rl(lf[7:0]) && rl(pr[`PR_LEAF]))
                return enclave_gate_pkg::out_dispatch_err;
        end
        return enclave_gate_pkg::out_dispatch;
    endfunction

    // Expected concurrency class of this leaf against the peer
    function automatic enclave_gate_pkg::conc_type exp_conc(
        input logic [7:0] lf, input logic [31:0] pr);
        if (!(pr[`PR_ACTIVE] & pr[`PR_SAME]) ||
            (lf == `LEAF_BLOCK && pr[`PR_IMPL]))
            return enclave_gate_pkg::conc_y;
        if (lf == `LEAF_TRACK && pr[`PR_LEAF] == `LEAF_TRACK)
            return enclave_gate_pkg::conc_n;
        if (rl(lf) && rl(pr[`PR_LEAF]))
            return enclave_gate_pkg::conc_c;
        return enclave_gate_pkg::conc_u;
    endfunction

    // Load all inputs, start, and compare; upper leaf word always random
    task automatic rc(input logic [31:0] op, input logic [31:0] m,
                      input logic [31:0] lf, input logic [63:0] bm,
                      input logic [31:0] pr);
        logic [31:0] q;
        logic e;
        int d0;
        enclave_gate_pkg::outcome_type eo;
        logic dl;
        apb(1'b1, `OFS_OPCODE, op, q, e);
        apb(1'b1, `OFS_MODE, m, q, e);
        apb(1'b1, `OFS_LEAF_LO, lf, q, e);
        apb(1'b1, `OFS_LEAF_HI, $urandom, q, e);
        apb(1'b1, `OFS_BMAP_LO, bm[31:0], q, e);
        apb(1'b1, `OFS_BMAP_HI, bm[63:32], q, e);
        apb(1'b1, `OFS_PEER, pr, q, e);
        d0 = disp_n;
        apb(1'b1, `OFS_CMD, 32'h0000_0001, q, e);
        repeat (3) @(posedge pclk);
        eo = exp_out(op, m, lf, bm, pr);
        dl = eo == enclave_gate_pkg::out_dispatch ||
             eo == enclave_gate_pkg::out_dispatch_err;
        chk("outcome", 32'(eo), 32'(result.outcome));
        chk("dispatch count", 32'(dl), 32'(disp_n - d0));
        if (dl || eo == enclave_gate_pkg::out_conc_fault)
        begin
            chk("leaf", 32'(lf[7:0]), 32'(result.leaf));
            chk("addr64", 32'(m[`MD_LMA] & m[`MD_CSL]),
                32'(result.addr64));
            chk("conc", 32'(exp_conc(lf[7:0], pr)),
                32'(result.conc));
            chk("roles", 32'(exp_roles(lf[7:0])),
                32'({result.rbx, result.rcx, result.rdx}));
        end
        // Answer must also be readable with its done flag set
        apb(1'b0, `OFS_RESULT, 32'h0000_0000, q, e);
        chk("result read", 32'({1'b1, eo}), 32'(q[21:17]));
        tno++;
        $display("test %0d done", tno);
    endtask

    // Main sequence: reset, register reset values, corners, random
    initial
    begin
        logic [31:0] q;
        logic e;
        logic [31:0] ud_modes [6];
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ud_modes = '{GOOD & ~32'h1, GOOD | 32'h4, GOOD | 32'h8,
                     GOOD & ~32'h40, GOOD | 32'h30, GOOD | 32'h10};
        void'($urandom(77));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("result at reset", 32'h0000_0000, 32'(result));
        for (int a = 0; a <= 32; a += 4)
        begin
            apb(1'b0, 12'(a), 32'h0000_0000, q, e);
            chk("reset read", 32'h0000_0000, q);
            chk("mapped slverr", 32'h0000_0000, 32'(e));
        end
        // Unmapped place answers with an error and zero data
        apb(1'b0, 12'h024, 32'h0000_0000, q, e);
        chk("unmapped slverr", 32'h0000_0001, 32'(e));
        chk("unmapped data", 32'h0000_0000, q);
        rc(OPC, 32'h0000_1000, 0, 0, 0);
        rc(32'h000F_01D7, GOOD, 0, 0, 0);
        rc(OPC | 32'hF000_0000, GOOD, 1, 0, 0);
        for (int i = 24; i < 28; i++)
            rc(OPC | (32'h1 << i), GOOD, 0, 0, 0);
        foreach (ud_modes[i])
            rc(OPC, ud_modes[i], 0, 0, 0);
        rc(OPC, GOOD | 32'h6000, 62, 64'h1 << 62, 0);
        rc(OPC, GOOD | 32'h6000, 63, 64'h1 << 62, 0);
        rc(OPC, GOOD | 32'h6000, 32'h40, 64'h1 << 63, 0);
        rc(OPC, GOOD | 32'h2000, 3, 64'h8, 0);
        rc(OPC, (GOOD & ~32'h80) | 32'h6000, 3, 64'h8, 0);
        rc(OPC, GOOD & ~32'h80, 0, 0, 0);
        rc(OPC, GOOD & ~32'h100, 0, 0, 0);
        rc(OPC, GOOD, 32'h10, 0, 0);
        rc(OPC, GOOD & ~32'h2, 0, 0, 0);
        rc(OPC, GOOD | 32'h0A00, 0, 0, 0);
        rc(OPC, GOOD | 32'h0E00, 5, 0, 0);
        rc(OPC, GOOD, 32'h0C, 0, 32'h030C);
        rc(OPC, GOOD, 32'h07, 0, 32'h0308);
        rc(OPC, GOOD, 32'h07, 0, 32'h0108);
        rc(OPC, GOOD, 32'h09, 0, 32'h070C);
        rc(OPC, GOOD, 32'h09, 0, 32'h030C);
        for (int i = 0; i < 60; i++)
            rc(($urandom % 8 == 0) ? OPC | (32'h1 << (24 + $urandom % 4))
                                   : OPC | ($urandom & 32'hF000_0000),
               ($urandom % 3 == 0) ? $urandom & 32'h0000_7FFF
                                   : GOOD | ($urandom & 32'h0000_6E00),
               ($urandom % 4 == 0) ? $urandom % 128 : $urandom % 16,
               {$urandom, $urandom},
               ($urandom & 32'h0000_0700) | (32'h7 + $urandom % 6)
              );
        // Mid-run reset must clear the answer and the mode register
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("result after reset", 32'h0000_0000, 32'(result));
        apb(1'b0, `OFS_MODE, 32'h0000_0000, q, e);
        chk("mode after reset", 32'h0000_0000, q);
        end_of_test();
    end
endmodule
